/* rtl/dc_point_sequencer.sv */
`timescale 1ns/100ps
`include "dcs_cfg.svh"

// Operation
// - Point mode holds up to 200 hold times, 0.1 to 12960000 ms each.
// - Point mode holds up to 200 voltages, paired by index with hold times.
// - Slope mode ramps between successive points over up to 200 programmed times.
// - Slope mode holds up to 200 voltages, the ramp endpoints.
// - Automatic step: one trigger runs all points without pause to the end.
// - Single step: each trigger advances exactly one step, then stops.
// - Program select chooses point tables or slope tables.
// - Status returns state, current node and current repetition.
// - States are idle, waiting for trigger, and active running.
// - Idle or waiting always reports node 1 and repetition 1.
// - Abort policy: off, restore live values, or keep last output.
// - Last abort policy freezes output at the abort instant.
// - End policy with same three choices applies on completion to idle.
// - Last end policy holds the final level, live values not restored.
// - End policy on normal completion only; abort policy on abort.
// - Repeat count 1 to 999999; larger means endless, reported as such.
module dc_point_sequencer #(
	parameter int VW   = 20,
	parameter int TW   = 27,
	parameter int RW   = 20,
	parameter int NPTS = `DCS_MAX_POINTS
)(
	// Clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// AXI4-Lite write
	input  wire logic [`DCS_ADDR_W-1:0] awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	// AXI4-Lite read
	input  wire logic [`DCS_ADDR_W-1:0] araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready,
	// Output stage
	output logic [VW-1:0]               out_volt,
	output logic                        out_en
);
	localparam int IW = 8;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Tables 0..3: point volt, point time, slope volt, slope time
	logic [31:0] tbl_q [4][NPTS];

	logic                        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0]                  bresp_q, rresp_q;
	logic [31:0]                 wdata_q, rdata_q;
	logic [3:0]                  wstrb_q;
	logic [`DCS_ADDR_W-1:0]      awaddr_q, araddr_q;
	logic                        single_q;
	dcs_pkg::table_sel_t         sel_q, run_sel_q;
	dcs_pkg::policy_t            abort_pol_q, end_pol_q;
	logic [RW-1:0]               repeat_q, rep_q;
	logic                        endless_q;
	logic [IW-1:0]               plen_q, slen_q, node_q;
	logic [VW-1:0]               live_volt_q, out_volt_q, target_q, delta_q;
	logic                        arm_q, trig_q, abort_q;
	dcs_pkg::seq_state_t         state_q;
	logic                        hold_q, start_q, out_en_q, follow_q, dir_q;
	logic [TW:0]                 err_q;
	logic [TW-1:0]               total_q;

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic        wr_do, rd_do, w_reg, w_tbl_ok, r_tbl_ok;
	logic [31:0] wmask, w_old, w_new, rd_data;
	logic [2:0]  w_region, r_region;
	logic [1:0]  w_tbl, r_tbl, rd_resp;
	logic [IW-1:0] w_idx, r_idx;

	assign wr_do    = !awready_q && !wready_q && !bvalid_q;
	assign rd_do    = !arready_q && !rvalid_q;
	assign wmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign w_region = awaddr_q[12:10];
	assign r_region = araddr_q[12:10];
	assign w_idx    = awaddr_q[9:2];
	assign r_idx    = araddr_q[9:2];
	assign w_tbl    = 2'(w_region - 3'h1);
	assign r_tbl    = 2'(r_region - 3'h1);
	assign w_reg    = (w_region == `DCS_REGION_REGS);
	assign w_tbl_ok = (w_region >= `DCS_REGION_PVOLT) && (w_region <= `DCS_REGION_STIME)
		&& (w_idx < IW'(NPTS));
	assign r_tbl_ok = (r_region >= `DCS_REGION_PVOLT) && (r_region <= `DCS_REGION_STIME)
		&& (r_idx < IW'(NPTS));
	assign w_old    = w_tbl_ok ? tbl_q[w_tbl][w_idx] : 32'h0000_0000;
	assign w_new    = (w_old & ~wmask) | (wdata_q & wmask);

	// Address and data are caught independently, in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= `DCS_RESP_OKAY;
			awaddr_q  <= '0;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end
		else
		begin
			if (awvalid && awready_q)
			begin
				awaddr_q  <= awaddr;
				awready_q <= 1'b0;
			end
			if (wvalid && wready_q)
			begin
				wdata_q  <= wdata;
				wstrb_q  <= wstrb;
				wready_q <= 1'b0;
			end
			if (wr_do)
			begin
				bvalid_q <= 1'b1;
				bresp_q  <= (w_tbl_ok || (w_reg && awaddr_q <= `DCS_OFF_LIVE))
					? `DCS_RESP_OKAY : `DCS_RESP_SLVERR;
			end
			if (bvalid_q && bready)
			begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= `DCS_RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
			araddr_q  <= '0;
		end
		else
		begin
			if (arvalid && arready_q)
			begin
				araddr_q  <= araddr;
				arready_q <= 1'b0;
			end
			if (rd_do)
			begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_data;
				rresp_q  <= rd_resp;
			end
			if (rvalid_q && rready)
			begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// Outside active the status shows node 1 and repetition 1
	logic [IW-1:0] node_rpt;
	logic [RW-1:0] rep_rpt;
	logic [1:0]    state_code;
	assign node_rpt = (state_q == dcs_pkg::SEQ_ACTIVE) ? node_q : IW'(1);
	assign rep_rpt  = (state_q == dcs_pkg::SEQ_ACTIVE) ? rep_q : RW'(1);
	assign state_code = (state_q == dcs_pkg::SEQ_ACTIVE) ? 2'h2 :
		(state_q == dcs_pkg::SEQ_WAIT) ? 2'h1 : 2'h0;

	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_resp = `DCS_RESP_OKAY;
		if (r_tbl_ok)
			rd_data = tbl_q[r_tbl][r_idx];
		else
		begin
			case (araddr_q)
				`DCS_OFF_CTRL:
				begin
					rd_data[`DCS_CTRL_SINGLE]      = single_q;
					rd_data[`DCS_CTRL_SLOPE]       = sel_q;
					rd_data[`DCS_CTRL_ABORT +: 2]  = abort_pol_q;
					rd_data[`DCS_CTRL_END +: 2]    = end_pol_q;
					rd_data[`DCS_CTRL_OUT_EN]      = out_en_q;
				end
				`DCS_OFF_CMD:    rd_data = 32'h0000_0000;
				`DCS_OFF_REPEAT: rd_data = endless_q ? 32'hffff_ffff : 32'(repeat_q);
				`DCS_OFF_PLEN:   rd_data = 32'(plen_q);
				`DCS_OFF_SLEN:   rd_data = 32'(slen_q);
				`DCS_OFF_LIVE:   rd_data = 32'(live_volt_q);
				`DCS_OFF_STATUS:
				begin
					rd_data[`DCS_ST_STATE +: 2] = state_code;
					rd_data[`DCS_ST_HOLD]       = hold_q;
					rd_data[`DCS_ST_ENDLESS]    = endless_q;
					rd_data[`DCS_ST_OUT_EN]     = out_en_q;
					rd_data[`DCS_ST_TABLE]      = run_sel_q;
					rd_data[`DCS_ST_NODE +: IW] = node_rpt;
				end
				`DCS_OFF_REP:    rd_data = 32'(rep_rpt);
				`DCS_OFF_OUT:    rd_data = 32'(out_volt_q);
				default:         rd_resp = `DCS_RESP_SLVERR;
			endcase
		end
	end

	// ----------------------------------------
	// Tables and settings
	// ----------------------------------------
	logic [31:0] t_val;
	always_comb
	begin
		t_val = w_new;
		if (w_tbl[0] && w_new < 32'(`DCS_TIME_MIN))
			t_val = 32'(`DCS_TIME_MIN);
		else if (w_tbl[0] && w_new > 32'(`DCS_TIME_MAX))
			t_val = 32'(`DCS_TIME_MAX);
	end

	// Table memory carries no reset, as a RAM would
	always_ff @(posedge aclk)
	begin
		if (wr_do && w_tbl_ok)
			tbl_q[w_tbl][w_idx] <= t_val;
	end

	logic wr_set;
	assign wr_set = wr_do && w_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			single_q    <= 1'(`DCS_CTRL_RST >> `DCS_CTRL_SINGLE);
			sel_q       <= dcs_pkg::TBL_POINT;
			abort_pol_q <= dcs_pkg::POL_OFF;
			end_pol_q   <= dcs_pkg::POL_OFF;
			repeat_q    <= RW'(`DCS_REPEAT_RST);
			endless_q   <= 1'b0;
			plen_q      <= IW'(`DCS_LEN_RST);
			slen_q      <= IW'(`DCS_LEN_RST);
			live_volt_q <= '0;
		end
		else if (wr_set)
		begin
			case (awaddr_q)
				`DCS_OFF_CTRL:
				begin
					single_q    <= w_new[`DCS_CTRL_SINGLE];
					sel_q       <= dcs_pkg::table_sel_t'(w_new[`DCS_CTRL_SLOPE]);
					abort_pol_q <= dcs_pkg::policy_t'(w_new[`DCS_CTRL_ABORT +: 2]);
					end_pol_q   <= dcs_pkg::policy_t'(w_new[`DCS_CTRL_END +: 2]);
				end
				`DCS_OFF_REPEAT:
				begin
					endless_q <= (w_new > 32'(`DCS_REPEAT_MAX));
					repeat_q  <= (w_new > 32'(`DCS_REPEAT_MAX)) ? RW'(`DCS_REPEAT_MAX)
						: (w_new == 32'h0) ? RW'(1) : RW'(w_new);
				end
				// Zero length cannot happen with a well-behaved host; clamp to one
				`DCS_OFF_PLEN: plen_q <= (w_new == 32'h0) ? IW'(1)
					: (w_new > 32'(NPTS)) ? IW'(NPTS) : IW'(w_new);
				`DCS_OFF_SLEN: slen_q <= (w_new == 32'h0) ? IW'(1)
					: (w_new > 32'(NPTS)) ? IW'(NPTS) : IW'(w_new);
				`DCS_OFF_LIVE: live_volt_q <= VW'(w_new);
				default: ;
			endcase
		end
	end

	// Command bits are one-cycle pulses
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arm_q   <= 1'b0;
			trig_q  <= 1'b0;
			abort_q <= 1'b0;
		end
		else
		begin
			arm_q   <= wr_set && awaddr_q == `DCS_OFF_CMD && w_new[`DCS_CMD_ARM];
			trig_q  <= wr_set && awaddr_q == `DCS_OFF_CMD && w_new[`DCS_CMD_TRIG];
			abort_q <= wr_set && awaddr_q == `DCS_OFF_CMD && w_new[`DCS_CMD_ABORT];
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	logic            tick, done, last_node, final_node, finish, abort_go, pol_evt, ramp_on;
	logic            ramp_step, active;
	logic [IW-1:0]   nidx, len;
	logic [VW-1:0]   cur_volt;
	logic [TW-1:0]   cur_time;
	dcs_pkg::policy_t pol;

	assign active     = (state_q == dcs_pkg::SEQ_ACTIVE);
	assign nidx       = node_q - IW'(1);
	assign len        = (run_sel_q == dcs_pkg::TBL_SLOPE) ? slen_q : plen_q;
	assign cur_volt   = tbl_q[{run_sel_q, 1'b0}][nidx][VW-1:0];
	assign cur_time   = tbl_q[{run_sel_q, 1'b1}][nidx][TW-1:0];
	assign last_node  = (node_q >= len);
	assign final_node = last_node && !endless_q && (rep_q >= repeat_q);
	assign abort_go   = abort_q && (state_q != dcs_pkg::SEQ_IDLE);
	assign finish     = active && done && final_node && !abort_go;
	assign pol_evt    = finish || abort_go;
	assign pol        = finish ? end_pol_q : abort_pol_q;

	point_hold_time_list_timer #(
		.TW       (TW)
	) u_timer (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.load     (start_q),
		.run      (active && !hold_q),
		.load_val (cur_time),
		.tick     (tick),
		.done     (done)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q   <= dcs_pkg::SEQ_IDLE;
			node_q    <= IW'(1);
			rep_q     <= RW'(1);
			hold_q    <= 1'b0;
			start_q   <= 1'b0;
			run_sel_q <= dcs_pkg::TBL_POINT;
		end
		else
		begin
			start_q <= 1'b0;
			case (state_q)
				dcs_pkg::SEQ_IDLE:
					if (arm_q)
					begin
						state_q   <= dcs_pkg::SEQ_WAIT;
						run_sel_q <= sel_q;
					end
				dcs_pkg::SEQ_WAIT:
					if (abort_go)
						state_q <= dcs_pkg::SEQ_IDLE;
					else if (trig_q)
					begin
						state_q <= dcs_pkg::SEQ_ACTIVE;
						node_q  <= IW'(1);
						rep_q   <= RW'(1);
						hold_q  <= 1'b0;
						start_q <= 1'b1;
					end
				dcs_pkg::SEQ_ACTIVE:
					if (abort_go || finish)
					begin
						state_q <= dcs_pkg::SEQ_IDLE;
						hold_q  <= 1'b0;
					end
					else if (hold_q && trig_q)
					begin
						hold_q  <= 1'b0;
						start_q <= 1'b1;
					end
					else if (done)
					begin
						node_q  <= last_node ? IW'(1) : node_q + IW'(1);
						// Endless runs stop counting at the top rather than wrap
						if (last_node && rep_q != {RW{1'b1}})
							rep_q <= rep_q + RW'(1);
						hold_q  <= single_q;
						start_q <= !single_q;
					end
				default: state_q <= dcs_pkg::SEQ_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Output stage
	// ----------------------------------------
	// Ramp moves 1 LSB per clock at most; steeper slopes lag and snap at node end
	assign ramp_on   = active && !hold_q && (run_sel_q == dcs_pkg::TBL_SLOPE);
	assign ramp_step = ramp_on && (err_q >= {1'b0, total_q}) && (out_volt_q != target_q);

	always_ff @(posedge aclk)
	begin
		if (!aresetn || start_q)
			err_q <= '0;
		else if (ramp_on)
			err_q <= err_q + (tick ? (TW+1)'(delta_q) : '0)
				- (ramp_step ? {1'b0, total_q} : '0);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			target_q <= '0;
			delta_q  <= '0;
			dir_q    <= 1'b0;
			total_q  <= TW'(1);
		end
		else if (start_q)
		begin
			target_q <= cur_volt;
			total_q  <= cur_time;
			dir_q    <= ($signed(cur_volt) > $signed(out_volt_q));
			delta_q  <= ($signed(cur_volt) > $signed(out_volt_q)) ? VW'(cur_volt - out_volt_q)
				: VW'(out_volt_q - cur_volt);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			out_volt_q <= '0;
		else if (pol_evt)
		begin
			if (pol == dcs_pkg::POL_OFF || pol == dcs_pkg::POL_LIVE)
				out_volt_q <= live_volt_q;
			else if (finish && run_sel_q == dcs_pkg::TBL_SLOPE)
				out_volt_q <= target_q;
		end
		else if (start_q && run_sel_q == dcs_pkg::TBL_POINT)
			out_volt_q <= cur_volt;
		else if (active && done && run_sel_q == dcs_pkg::TBL_SLOPE)
			out_volt_q <= target_q;
		else if (ramp_step)
			out_volt_q <= dir_q ? out_volt_q + VW'(1) : out_volt_q - VW'(1);
		else if (state_q == dcs_pkg::SEQ_IDLE && follow_q)
			out_volt_q <= live_volt_q;
	end

	// Last policy stops following live values until a later run ends otherwise
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			follow_q <= 1'b1;
		else if (pol_evt)
			follow_q <= (pol == dcs_pkg::POL_OFF || pol == dcs_pkg::POL_LIVE);
	end

	// Policy off overrides a same-cycle software enable
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			out_en_q <= 1'b0;
		else if (pol_evt && pol == dcs_pkg::POL_OFF)
			out_en_q <= 1'b0;
		else if (wr_set && awaddr_q == `DCS_OFF_CTRL && wstrb_q[1])
			out_en_q <= w_new[`DCS_CTRL_OUT_EN];
	end

	assign awready  = awready_q;
	assign wready   = wready_q;
	assign bresp    = bresp_q;
	assign bvalid   = bvalid_q;
	assign arready  = arready_q;
	assign rdata    = rdata_q;
	assign rresp    = rresp_q;
	assign rvalid   = rvalid_q;
	assign out_volt = out_volt_q;
	assign out_en   = out_en_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_idle_report: assert property (rd_do && !active |=> rvalid_q
		&& (araddr_q != `DCS_OFF_REP || rdata_q == 32'h0000_0001)
		&& (araddr_q != `DCS_OFF_STATUS || rdata_q[`DCS_ST_NODE +: IW] == IW'(1)))
		else $error("idle or wait reports node or repetition other than 1");
	a_trig_start: assert property (state_q == dcs_pkg::SEQ_WAIT && trig_q && !abort_go
		|=> active && start_q && node_q == IW'(1))
		else $error("trigger in wait did not start node 1");
	a_abort_last: assert property (abort_go && abort_pol_q == dcs_pkg::POL_LAST
		|=> $stable(out_volt_q) && state_q == dcs_pkg::SEQ_IDLE)
		else $error("last abort policy changed the output");
	a_abort_off: assert property (abort_go && abort_pol_q == dcs_pkg::POL_OFF
		|=> !out_en_q && out_volt_q == $past(live_volt_q))
		else $error("off abort policy did not disable and restore");
	a_end_live: assert property (finish && end_pol_q == dcs_pkg::POL_LIVE
		|=> out_volt_q == $past(live_volt_q) && out_en_q == $past(out_en_q))
		else $error("live end policy did not restore setpoint");
	a_single_hold: assert property (active && done && !finish && !abort_go && single_q
		|=> hold_q && !start_q ##1 !start_q)
		else $error("single step did not stop after one step");
	a_auto_next: assert property (active && done && !finish && !abort_go && !single_q
		&& !hold_q |=> start_q && !hold_q)
		else $error("automatic step paused between points");
	a_node_wrap: assert property (active && done && last_node && !finish && !abort_go
		&& !hold_q |=> node_q == IW'(1))
		else $error("node did not wrap to 1 after last point");
	a_point_volt: assert property (start_q && run_sel_q == dcs_pkg::TBL_POINT && !pol_evt
		|=> out_volt_q == $past(cur_volt))
		else $error("point voltage not applied at node start");
	a_endless_set: assert property (wr_set && awaddr_q == `DCS_OFF_REPEAT
		&& w_new > 32'(`DCS_REPEAT_MAX) |=> endless_q)
		else $error("large repeat count not taken as endless");

	c_auto_finish: cover property (finish && !single_q);
	c_single_step: cover property (hold_q && trig_q);
	c_abort_run: cover property (abort_go && active);
	c_slope_ramp: cover property (ramp_step);

endmodule : dc_point_sequencer

/* rtl/dcs_cfg.svh */
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH

// ----------------------------------------
// Bus map
// ----------------------------------------
`define DCS_ADDR_W        13
`define DCS_OFF_CTRL      13'h0000
`define DCS_OFF_CMD       13'h0004
`define DCS_OFF_REPEAT    13'h0008
`define DCS_OFF_PLEN      13'h000c
`define DCS_OFF_SLEN      13'h0010
`define DCS_OFF_LIVE      13'h0014
`define DCS_OFF_STATUS    13'h0018
`define DCS_OFF_REP       13'h001c
`define DCS_OFF_OUT       13'h0020
// Table windows: region = addr[12:10], entry = addr[9:2]
`define DCS_REGION_REGS   3'h0
`define DCS_REGION_PVOLT  3'h1
`define DCS_REGION_PTIME  3'h2
`define DCS_REGION_SVOLT  3'h3
`define DCS_REGION_STIME  3'h4
`define DCS_RESP_OKAY     2'h0
`define DCS_RESP_SLVERR   2'h2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCS_CTRL_SINGLE   0
`define DCS_CTRL_SLOPE    1
`define DCS_CTRL_ABORT    2
`define DCS_CTRL_END      4
`define DCS_CTRL_OUT_EN   8
`define DCS_CMD_ARM       0
`define DCS_CMD_TRIG      1
`define DCS_CMD_ABORT     2
`define DCS_ST_STATE      0
`define DCS_ST_HOLD       2
`define DCS_ST_ENDLESS    3
`define DCS_ST_OUT_EN     4
`define DCS_ST_TABLE      5
`define DCS_ST_NODE       8

// ----------------------------------------
// Limits, reset values and timing
// ----------------------------------------
`define DCS_MAX_POINTS    200
`define DCS_REPEAT_MAX    999999
`define DCS_REPEAT_RST    1
`define DCS_LEN_RST       1
`define DCS_CTRL_RST      32'h0000_0000
`define DCS_TIME_MIN      1
`define DCS_TIME_MAX      129600000
`define DCS_TIME_UNIT_NS  100000
`define DCS_CLK_PERIOD_NS 50

`endif

/* rtl/dcs_pkg.sv */
package dcs_pkg;

	typedef enum logic [2:0]
	{
		SEQ_IDLE   = 3'b001,
		SEQ_WAIT   = 3'b010,
		SEQ_ACTIVE = 3'b100
	} seq_state_t;

	typedef enum logic [1:0]
	{
		POL_OFF  = 2'h0,
		POL_LIVE = 2'h1,
		POL_LAST = 2'h2
	} policy_t;

	typedef enum logic
	{
		TBL_POINT = 1'b0,
		TBL_SLOPE = 1'b1
	} table_sel_t;

endpackage : dcs_pkg

/* rtl/point_hold_time_list_timer.sv */
`timescale 1ns/100ps
`include "dcs_cfg.svh"

// Counts node time in 0.1 ms units; done pulses on the last unit
module point_hold_time_list_timer #(
	parameter int TW          = 27,
	parameter int TICK_CYCLES = (`DCS_TIME_UNIT_NS + `DCS_CLK_PERIOD_NS - 1) / `DCS_CLK_PERIOD_NS
)(
	// Clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// Control
	input  wire logic          load,
	input  wire logic          run,
	input  wire logic [TW-1:0] load_val,
	// Status
	output logic               tick,
	output logic               done
);
	localparam int DW = $clog2(TICK_CYCLES + 1);

	logic [DW-1:0] div_q;
	logic [TW-1:0] remain_q;

	assign tick = run && !load && (div_q == DW'(TICK_CYCLES - 1));
	assign done = tick && (remain_q == TW'(1));

	// Divider restarts on each load so a node gets its full first unit
	always_ff @(posedge aclk)
	begin
		if (!aresetn || load || !run || tick)
			div_q <= '0;
		else
			div_q <= div_q + DW'(1);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			remain_q <= '0;
		else if (load)
			remain_q <= load_val;
		else if (tick && remain_q != '0)
			remain_q <= remain_q - TW'(1);
	end

endmodule : point_hold_time_list_timer

/* verif/dc_point_sequencer_test.sv */
`timescale 1ns/100ps
`include "dcs_cfg.svh"

module dc_point_sequencer_test;
	logic                   aclk, aresetn, out_en;
	logic [`DCS_ADDR_W-1:0] awaddr, araddr;
	logic                   awvalid, awready, wvalid, wready, bvalid, bready;
	logic                   arvalid, arready, rvalid, rready;
	logic [31:0]            wdata, rdata, d;
	logic [3:0]             wstrb;
	logic [1:0]             bresp, rresp, r;
	logic [19:0]            out_volt;
	int                     error_cnt = 0, num_checks = 0, cyc = 0;

	dc_point_sequencer dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .out_volt, .out_en);
	dcs_host host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready);

	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// ------------------------------
	// Helpers
	// ------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic w(input logic [12:0] a, input logic [31:0] v);
		host.wr(a, v, r);
	endtask : w

	task automatic rx(input logic [12:0] a, input logic [31:0] m, input logic [31:0] e,
		input string n);
		host.rd(a, d, r);
		chk(n, d & m, e);
	endtask : rx

	function automatic logic [12:0] ta(input logic [2:0] g, input int i);
		return {g, i[7:0], 2'b00};
	endfunction : ta

	// Poll status; the run timeout bounds it
	task automatic wait_idle();
		d = 32'h1;
		while (d[1:0] !== 2'h0)
			host.rd(`DCS_OFF_STATUS, d, r);
	endtask : wait_idle

	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_regs();
		rx(`DCS_OFF_STATUS, 32'hff03, 32'h0100, "status");
		w(`DCS_OFF_REPEAT, 32'd1000000);
		rx(`DCS_OFF_REPEAT, 32'hffffffff, 32'hffffffff, "repeat");
		w(ta(`DCS_REGION_PTIME, 0), 32'h0);
		rx(ta(`DCS_REGION_PTIME, 0), 32'hffffffff, 32'h1, "tmin");
		w(ta(`DCS_REGION_STIME, 1), 32'hffffffff);
		rx(ta(`DCS_REGION_STIME, 1), 32'hffffffff, 32'h07b98a00, "tmax");
		host.rd(ta(`DCS_REGION_PVOLT, 200), d, r);
		chk("resp", {30'h0, r}, {30'h0, `DCS_RESP_SLVERR});
	endtask : t_regs

	// Two points, two passes, end keeps last level
	task automatic t_auto();
		w(`DCS_OFF_REPEAT, 32'd2);
		w(`DCS_OFF_PLEN, 32'd2);
		w(ta(`DCS_REGION_PVOLT, 0), 32'd100);
		w(ta(`DCS_REGION_PVOLT, 1), 32'd200);
		w(ta(`DCS_REGION_PTIME, 1), 32'd1);
		w(`DCS_OFF_LIVE, 32'd5);
		w(`DCS_OFF_CTRL, 32'h0000_0120);
		w(`DCS_OFF_CMD, 32'h1);
		rx(`DCS_OFF_STATUS, 32'hff03, 32'h0101, "wait");
		rx(`DCS_OFF_REP, 32'hffffffff, 32'h1, "rep");
		w(`DCS_OFF_CMD, 32'h2);
		repeat (1000) @(posedge aclk);
		chk("volt1", {12'h0, out_volt}, 32'd100);
		repeat (4000) @(posedge aclk);
		rx(`DCS_OFF_REP, 32'hffffffff, 32'h2, "rep2");
		rx(`DCS_OFF_STATUS, 32'hff03, 32'h0102, "active");
		wait_idle();
		chk("endv", {12'h0, out_volt}, 32'd200);
		chk("ene", {31'h0, out_en}, 32'h1);
	endtask : t_auto

	// Single step, abort freezes level, then live and off aborts from wait
	task automatic t_single();
		w(`DCS_OFF_CTRL, 32'h0000_0109);
		w(`DCS_OFF_CMD, 32'h1);
		w(`DCS_OFF_CMD, 32'h2);
		repeat (3000) @(posedge aclk);
		rx(`DCS_OFF_STATUS, 32'hff07, 32'h0206, "hold");
		w(`DCS_OFF_CMD, 32'h2);
		repeat (1000) @(posedge aclk);
		chk("step2", {12'h0, out_volt}, 32'd200);
		w(`DCS_OFF_CMD, 32'h4);
		rx(`DCS_OFF_STATUS, 32'hff03, 32'h0100, "abort");
		chk("abv", {12'h0, out_volt}, 32'd200);
		w(`DCS_OFF_LIVE, 32'd9);
		rx(`DCS_OFF_OUT, 32'h000fffff, 32'd200, "frz");
		w(`DCS_OFF_CTRL, 32'h0000_0104);
		w(`DCS_OFF_CMD, 32'h1);
		w(`DCS_OFF_CMD, 32'h4);
		rx(`DCS_OFF_OUT, 32'h000fffff, 32'd9, "abl");
		rx(`DCS_OFF_STATUS, 32'h13, 32'h10, "abe");
		w(`DCS_OFF_CTRL, 32'h0000_0100);
		w(`DCS_OFF_CMD, 32'h1);
		w(`DCS_OFF_CMD, 32'h4);
		rx(`DCS_OFF_STATUS, 32'h13, 32'h00, "abo");
	endtask : t_single

	// Two slope nodes, end restores live value and keeps enable
	task automatic t_slope();
		w(`DCS_OFF_REPEAT, 32'd1);
		w(`DCS_OFF_SLEN, 32'd2);
		w(ta(`DCS_REGION_SVOLT, 0), 32'd50);
		w(ta(`DCS_REGION_SVOLT, 1), 32'd60);
		w(ta(`DCS_REGION_STIME, 0), 32'd1);
		w(ta(`DCS_REGION_STIME, 1), 32'd2);
		w(`DCS_OFF_CTRL, 32'h0000_0112);
		w(`DCS_OFF_CMD, 32'h1);
		w(`DCS_OFF_CMD, 32'h2);
		repeat (3000) @(posedge aclk);
		chk("slope", {12'h0, out_volt}, 32'd50);
		rx(`DCS_OFF_STATUS, 32'h23, 32'h22, "tbl");
		repeat (2000) @(posedge aclk);
		chk("ramp", {31'h0, out_volt > 20'd50 && out_volt < 20'd60}, 32'h1);
		wait_idle();
		chk("livev", {12'h0, out_volt}, 32'd9);
		chk("livee", {31'h0, out_en}, 32'h1);
	endtask : t_slope

	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			error_cnt++;
			stop_test();
		end
	end

	initial
	begin
		aresetn = 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_auto();
		t_single();
		t_slope();
		stop_test();
	end
endmodule : dc_point_sequencer_test

/* verif/dcs_host.sv */
`timescale 1ns/100ps
`include "dcs_cfg.svh"

// AXI4-Lite master standing in for the remote controller
module dcs_host (
	// Clock
	input  wire logic                   aclk,
	// Write channels
	output logic [`DCS_ADDR_W-1:0]      awaddr,
	output logic                        awvalid,
	input  wire logic                   awready,
	output logic [31:0]                 wdata,
	output logic [3:0]                  wstrb,
	output logic                        wvalid,
	input  wire logic                   wready,
	input  wire logic [1:0]             bresp,
	input  wire logic                   bvalid,
	output logic                        bready,
	// Read channels
	output logic [`DCS_ADDR_W-1:0]      araddr,
	output logic                        arvalid,
	input  wire logic                   arready,
	input  wire logic [31:0]            rdata,
	input  wire logic [1:0]             rresp,
	input  wire logic                   rvalid,
	output logic                        rready
);
	initial
	begin
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		wstrb = 4'hf;
	end

	// One whole entry per list write, never an empty list
	task automatic wr(input logic [12:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				rs = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task automatic rd(input logic [12:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				v = rdata;
				rs = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : rd
endmodule : dcs_host
